/* File: rtl/ipqsc_frame_if.sv */
// Interface carrying per-frame information from the pipeline to the statistics block.
`timescale 1ns/1ns
`default_nettype none
interface ipqsc_frame_if;
	import ipqsc_pkg::*;
	logic valid; // One-cycle strobe: a frame is presented.
	logic [PORT_W-1:0] port; // Ingress port.
	logic [PRIO_W-1:0] prio; // Internal priority.
	logic error; // Frame is errored.
	logic no_dest; // Frame has no destination.
	logic [BYTES_W-1:0] bytes; // Frame length in bytes.
	logic [EVT_W-1:0] events; // Event vector.
	logic [QEV_W-1:0] qev; // Queue policer events: pass and drop.

	// The pipeline end drives the frame.
	modport pipe (output valid, output port, output prio, output error, output no_dest,
		output bytes, output events, output qev);
	// The statistics end consumes it.
	modport dev (input valid, input port, input prio, input error, input no_dest,
		input bytes, input events, input qev);
endinterface
`default_nettype wire

/* File: rtl/ipqsc_pipe.sv */
// Pipeline end: registers a frame request and presents it to the statistics block.
`timescale 1ns/1ns
`default_nettype none
module ipqsc_pipe (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req_valid,
	input wire logic [ipqsc_pkg::PORT_W-1:0] req_port,
	input wire logic [ipqsc_pkg::PRIO_W-1:0] req_prio,
	input wire logic req_error,
	input wire logic req_no_dest,
	input wire logic [ipqsc_pkg::BYTES_W-1:0] req_bytes,
	input wire logic [ipqsc_pkg::EVT_W-1:0] req_events,
	input wire logic [ipqsc_pkg::QEV_W-1:0] req_qev,
	ipqsc_frame_if.pipe frm
);
	import ipqsc_pkg::*;

	// The strobe is registered so the far end sees clean flop outputs.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frm.valid <= 1'b0;
		end else begin
			frm.valid <= req_valid;
		end
	end

	// Frame fields are captured with every request and held otherwise.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frm.port <= '0;
			frm.prio <= '0;
			frm.error <= 1'b0;
			frm.no_dest <= 1'b0;
			frm.bytes <= '0;
			frm.events <= '0;
			frm.qev <= '0;
		end else if (req_valid) begin
			frm.port <= req_port;
			frm.prio <= req_prio;
			frm.error <= req_error;
			frm.no_dest <= req_no_dest;
			frm.bytes <= req_bytes;
			frm.events <= req_events;
			frm.qev <= req_qev;
		end
	end
endmodule // ipqsc_pipe
`default_nettype wire

/* File: rtl/ipqsc_pkg.sv */
// Package with sizes, register map, field layouts and encodings of the statistics counters.
package ipqsc_pkg;
	// Counter structure.
	localparam int NUM_PORTS = 4;
	localparam int PORT_W = 2;
	localparam int NUM_PRIO = 8;
	localparam int PRIO_W = 3;
	localparam int NUM_PCNT = 4;
	localparam int NUM_QCNT = 2;
	localparam int NUM_QUEUES = NUM_PORTS * NUM_PRIO;
	localparam int CNT_W = 40;
	localparam int LOW_W = 32;
	localparam int HIGH_W = 8;
	localparam int EVT_W = 12;
	localparam int BYTES_W = 14;
	localparam int QEV_W = 2;
	localparam int CLS_W = 3;
	localparam int CFG_W = 12;
	localparam int ADDR_W = 12;

	// Register byte offsets and region sizes.
	localparam logic [11:0] GMASK_BASE = 12'h000;
	localparam logic [11:0] GMASK_SIZE = 12'h010;
	localparam logic [11:0] CLEAR_ADDR = 12'h010;
	localparam logic [11:0] QMODE_ADDR = 12'h014;
	localparam logic [11:0] QMASK_BASE = 12'h018;
	localparam logic [11:0] QMASK_SIZE = 12'h008;
	localparam logic [11:0] FLAGS_BASE = 12'h040;
	localparam logic [11:0] FLAGS_SIZE = 12'h010;
	localparam logic [11:0] CFG_BASE = 12'h080;
	localparam logic [11:0] CFG_SIZE = 12'h040;
	localparam logic [11:0] PCNT_BASE = 12'h100;
	localparam logic [11:0] PCNT_SIZE = 12'h080;
	localparam logic [11:0] QCNT_BASE = 12'h200;
	localparam logic [11:0] QCNT_SIZE = 12'h200;

	// Field positions inside a port counter configuration word.
	localparam int CFG_PRIO_LSB = 0;
	localparam int CFG_CLASS_LSB = 8;
	localparam int CFG_BYTE_BIT = 11;
	// Bit of the clear control word that starts the clear.
	localparam int CLEAR_BIT = 0;
	// Queue event bits.
	localparam int QEV_PASS_BIT = 0;
	localparam int QEV_DROP_BIT = 1;

	// Reset values.
	localparam logic [11:0] CFG_RESET = 12'h0FF;
	localparam logic [11:0] GMASK_RESET = 12'h000;
	localparam logic [1:0] QMASK_RESET = 2'h0;
	localparam logic [1:0] QMODE_RESET = 2'h0;

	// Frame class selector encodings.
	typedef enum logic [2:0] {
		IPQSC_CLS_OK_NOMATCH = 3'h0,
		IPQSC_CLS_OK_MATCH = 3'h1,
		IPQSC_CLS_ERR_MATCH = 3'h2,
		IPQSC_CLS_ANY_MATCH = 3'h3,
		IPQSC_CLS_ERR_NOMATCH = 3'h4,
		IPQSC_CLS_ANY_ERR = 3'h5
	} ipqsc_class_e;

	typedef logic [CNT_W-1:0] ipqsc_cnt_t;
endpackage

/* File: rtl/ipqsc_stats.sv */
// Statistics end: port and queue counters with an APB register slave.
`timescale 1ns/1ns
`default_nettype none
module ipqsc_stats (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ipqsc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	ipqsc_frame_if.dev frm
);
	import ipqsc_pkg::*;

	ipqsc_cnt_t pcnt [0:NUM_PORTS*NUM_PCNT-1]; // Port counters, index port*4+counter.
	ipqsc_cnt_t qcnt [0:NUM_QUEUES*NUM_QCNT-1]; // Queue counters, index queue*2+type.
	logic [CFG_W-1:0] cfg [0:NUM_PORTS*NUM_PCNT-1]; // Per-port per-counter configuration.
	logic [EVT_W-1:0] gmask [0:NUM_PCNT-1]; // Event mask shared by all ports.
	logic [QEV_W-1:0] qmask [0:NUM_QCNT-1]; // Event mask per queue counter type.
	logic [NUM_QCNT-1:0] qmode; // Byte mode per queue counter type.
	logic [EVT_W-1:0] flags [0:NUM_PORTS-1]; // Sticky event flags per port.
	logic [HIGH_W-1:0] shadow; // High bits latched by the last low-word read.
	logic [HIGH_W-1:0] shadow_pend; // High bits sampled in the setup cycle of a low read.
	logic [LOW_W-1:0] wlatch; // First half of a two-part counter write.

	logic setup; // APB setup cycle.
	logic acc; // APB access completes at this edge.
	logic wr; // A legal write completes at this edge.
	logic clear; // Global counter clear is being written.
	logic in_gmask, in_qmask, in_flags, in_cfg, in_pcnt, in_qcnt; // Address decode.
	logic [31:0] rd_val; // Read data for the current address.
	logic rd_err; // Current address is not mapped.
	logic frm_err; // Errored frame, including frames without destination.
	logic [NUM_PCNT-1:0] phit; // Per counter index: frame is counted.
	ipqsc_cnt_t pinc [0:NUM_PCNT-1]; // Per counter index: amount to add.
	logic [NUM_QCNT-1:0] qhit; // Per queue type: frame is counted.
	ipqsc_cnt_t qinc [0:NUM_QCNT-1]; // Per queue type: amount to add.
	logic [PORT_W+PRIO_W-1:0] qidx; // Queue of the current frame.

	assign setup = psel & ~penable;
	assign acc = psel & penable & pready;
	assign wr = acc & pwrite & ~pslverr;
	assign clear = wr & (paddr == CLEAR_ADDR) & pwdata[CLEAR_BIT];
	assign frm_err = frm.error | frm.no_dest;
	assign qidx = {frm.port, frm.prio};

	// Region decode; only word-aligned addresses are mapped.
	assign in_gmask = (paddr >= GMASK_BASE) && (paddr < GMASK_BASE + GMASK_SIZE);
	assign in_qmask = (paddr >= QMASK_BASE) && (paddr < QMASK_BASE + QMASK_SIZE);
	assign in_flags = (paddr >= FLAGS_BASE) && (paddr < FLAGS_BASE + FLAGS_SIZE);
	assign in_cfg = (paddr >= CFG_BASE) && (paddr < CFG_BASE + CFG_SIZE);
	assign in_pcnt = (paddr >= PCNT_BASE) && (paddr < PCNT_BASE + PCNT_SIZE);
	assign in_qcnt = (paddr >= QCNT_BASE) && (paddr < QCNT_BASE + QCNT_SIZE);

	// Count decision per port counter index, using the ingress port's configuration.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PCNT; gi++) begin : g_pdec
			logic [CFG_W-1:0] c; // Configuration of this counter on the ingress port.
			logic match; // Event selection hit.
			logic sel; // Frame class condition holds.
			assign c = cfg[{frm.port, 2'(gi)}];
			assign match = |(gmask[gi] & frm.events);
			// Class selector; unused encodings never count.
			always_comb begin
				sel = 1'b0;
				case (c[CFG_CLASS_LSB +: CLS_W])
					IPQSC_CLS_OK_NOMATCH: sel = ~frm_err & ~match;
					IPQSC_CLS_OK_MATCH: sel = ~frm_err & match;
					IPQSC_CLS_ERR_MATCH: sel = frm_err & match;
					IPQSC_CLS_ANY_MATCH: sel = match;
					IPQSC_CLS_ERR_NOMATCH: sel = frm_err & ~match;
					IPQSC_CLS_ANY_ERR: sel = frm_err;
					default: sel = 1'b0;
				endcase
			end
			assign phit[gi] = frm.valid & c[CFG_PRIO_LSB + frm.prio] & sel;
			assign pinc[gi] = c[CFG_BYTE_BIT] ? ipqsc_cnt_t'(frm.bytes) : ipqsc_cnt_t'(1);
		end
		// Count decision per queue counter type, global for all queues.
		for (gi = 0; gi < NUM_QCNT; gi++) begin : g_qdec
			assign qhit[gi] = frm.valid & |(qmask[gi] & frm.qev);
			assign qinc[gi] = qmode[gi] ? ipqsc_cnt_t'(frm.bytes) : ipqsc_cnt_t'(1);
		end
	endgenerate

	// Read mux; the high word of a counter reads the shadow, not the live counter.
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		if (paddr[1:0] != 2'h0) begin
			rd_err = 1'b1;
		end else if (in_gmask) begin
			rd_val = {20'h0_0000, gmask[paddr[3:2]]};
		end else if (paddr == CLEAR_ADDR) begin
			rd_val = 32'h0000_0000;
		end else if (paddr == QMODE_ADDR) begin
			rd_val = {30'h0000_0000, qmode};
		end else if (in_qmask) begin
			rd_val = {30'h0000_0000, qmask[paddr[2]]};
		end else if (in_flags) begin
			rd_val = {20'h0_0000, flags[paddr[3:2]]};
		end else if (in_cfg) begin
			rd_val = {20'h0_0000, cfg[paddr[5:2]]};
		end else if (in_pcnt) begin
			rd_val = paddr[2] ? {24'h00_0000, shadow} : pcnt[paddr[6:3]][LOW_W-1:0];
		end else if (in_qcnt) begin
			rd_val = paddr[2] ? {24'h00_0000, shadow} : qcnt[paddr[8:3]][LOW_W-1:0];
		end else begin
			rd_err = 1'b1;
		end
	end

	// APB answer: data sampled in setup, pready high for exactly the one access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_val;
				pslverr <= rd_err;
			end
		end
	end

	// Shadow of the high bits: sampled with the low data so both halves are coherent.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shadow_pend <= '0;
			shadow <= '0;
		end else begin
			if (setup & ~pwrite & ~paddr[2] & (paddr[1:0] == 2'h0)) begin
				shadow_pend <= in_pcnt ? pcnt[paddr[6:3]][CNT_W-1:LOW_W] : qcnt[paddr[8:3]][CNT_W-1:LOW_W];
			end
			if (acc & ~pwrite & ~pslverr & ~paddr[2] & (in_pcnt | in_qcnt)) begin
				shadow <= shadow_pend;
			end
		end
	end

	// Write latch: port low word and queue high word are held until their partner arrives.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wlatch <= '0;
		end else if (wr & in_pcnt & ~paddr[2]) begin
			wlatch <= pwdata;
		end else if (wr & in_qcnt & paddr[2]) begin
			wlatch <= {24'h00_0000, pwdata[HIGH_W-1:0]};
		end
	end

	// Configuration registers; they are not touched by the counter clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < NUM_PORTS*NUM_PCNT; k++) begin
				cfg[k] <= CFG_RESET;
			end
			for (int k = 0; k < NUM_PCNT; k++) begin
				gmask[k] <= GMASK_RESET;
			end
			for (int k = 0; k < NUM_QCNT; k++) begin
				qmask[k] <= QMASK_RESET;
			end
			qmode <= QMODE_RESET;
		end else if (wr) begin
			if (in_cfg) begin
				cfg[paddr[5:2]] <= pwdata[CFG_W-1:0];
			end
			if (in_gmask) begin
				gmask[paddr[3:2]] <= pwdata[EVT_W-1:0];
			end
			if (in_qmask) begin
				qmask[paddr[2]] <= pwdata[QEV_W-1:0];
			end
			if (paddr == QMODE_ADDR) begin
				qmode <= pwdata[NUM_QCNT-1:0];
			end
		end
	end

	// Sticky flags: the frame's events set them, write-one clears, setting wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				flags[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (clear) begin
					flags[p] <= '0;
				end else begin
					flags[p] <= (flags[p] & ~((wr & in_flags & (paddr[3:2] == p[1:0])) ? pwdata[EVT_W-1:0] : '0))
						| ((frm.valid & (frm.port == p[PORT_W-1:0])) ? frm.events : '0);
				end
			end
		end
	end

	// Port counters; a software write to the same counter overrides a count in that cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < NUM_PORTS*NUM_PCNT; k++) begin
				pcnt[k] <= '0;
			end
		end else if (clear) begin
			for (int k = 0; k < NUM_PORTS*NUM_PCNT; k++) begin
				pcnt[k] <= '0;
			end
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				for (int i = 0; i < NUM_PCNT; i++) begin
					if (phit[i] & (frm.port == p[PORT_W-1:0])) begin
						pcnt[p*NUM_PCNT+i] <= pcnt[p*NUM_PCNT+i] + pinc[i];
					end
				end
			end
			if (wr & in_pcnt & paddr[2]) begin
				pcnt[paddr[6:3]] <= {pwdata[HIGH_W-1:0], wlatch};
			end
		end
	end

	// Queue counters; the low-word write commits the whole value.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < NUM_QUEUES*NUM_QCNT; k++) begin
				qcnt[k] <= '0;
			end
		end else if (clear) begin
			for (int k = 0; k < NUM_QUEUES*NUM_QCNT; k++) begin
				qcnt[k] <= '0;
			end
		end else begin
			for (int t = 0; t < NUM_QCNT; t++) begin
				if (qhit[t]) begin
					qcnt[{qidx, t[0]}] <= qcnt[{qidx, t[0]}] + qinc[t];
				end
			end
			if (wr & in_qcnt & ~paddr[2]) begin
				qcnt[paddr[8:3]] <= {wlatch[HIGH_W-1:0], pwdata};
			end
		end
	end
endmodule // ipqsc_stats
`default_nettype wire

/* File: verification/ingress_port_queue_stat_counters_tb_top.sv */
// Testbench joining pipeline and statistics ends, driving APB and frames.
`timescale 1ns/1ns
`default_nettype none
module ingress_port_queue_stat_counters_tb_top;
	import ipqsc_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic req_valid = 0;
	logic [PORT_W-1:0] req_port = '0;
	logic [PRIO_W-1:0] req_prio = '0;
	logic req_error = 0;
	logic req_no_dest = 0;
	logic [BYTES_W-1:0] req_bytes = '0;
	logic [EVT_W-1:0] req_events = '0;
	logic [QEV_W-1:0] req_qev = '0;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	int c;
	int n;
	logic [31:0] rd; // Last read data.
	logic e; // Last error flag.
	logic [39:0] v; // Last 40-bit counter.

	ipqsc_frame_if frm_link ();
	ipqsc_pipe ipqsc_pipe_i (.pclk(pclk), .presetn(presetn), .req_valid(req_valid), .req_port(req_port),
		.req_prio(req_prio), .req_error(req_error), .req_no_dest(req_no_dest), .req_bytes(req_bytes),
		.req_events(req_events), .req_qev(req_qev), .frm(frm_link));
	ipqsc_stats ipqsc_stats_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frm(frm_link));
	ipqsc_properties ipqsc_properties_i (.pclk(pclk), .presetn(presetn), .req_valid(req_valid),
		.req_events(req_events), .req_bytes(req_bytes), .valid(frm_link.valid), .events(frm_link.events),
		.bytes(frm_link.bytes), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// Clock at 20 MHz.
	initial forever #25 pclk = ~pclk;

	// Hang guard: the whole run needs well under two thousand cycles.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			close_out();
		end
	end

	task automatic close_out;
		$display("compares %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [39:0] g, input logic [39:0] x);
		tests_run++;
		if (g !== x) begin
			err_total++;
			$display("BAD t=%0t got %h want %h", $time, g, x);
		end
	endtask

	// One APB transfer; pready is looked at mid-cycle so the deciding edge is known.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(negedge pclk);
		while (pready !== 1'b1)
			@(negedge pclk);
		@(posedge pclk);
		rd = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask

	// Low word first so the high part comes from the shadow.
	task automatic rd40(input logic [11:0] a);
		apb(0, a, 0);
		v[31:0] = rd;
		apb(0, a + 12'h004, 0);
		v[39:32] = rd[7:0];
	endtask

	task automatic frame(input logic [1:0] p, input logic [2:0] q, input logic er, input logic nd,
		input logic [13:0] b, input logic [11:0] ev, input logic [1:0] qe);
		@(posedge pclk);
		req_valid <= 1;
		req_port <= p;
		req_prio <= q;
		req_error <= er;
		req_no_dest <= nd;
		req_bytes <= b;
		req_events <= ev;
		req_qev <= qe;
		@(posedge pclk);
		req_valid <= 0;
	endtask

	// Expected counting decision of one frame class code.
	function automatic int hit(int k, logic er, logic m);
		return int'((k == 0 && !er && !m) || (k == 1 && !er && m) || (k == 2 && er && m) || (k == 3 && m)
			|| (k == 4 && er && !m) || (k == 5 && er));
	endfunction

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		wr(CLEAR_ADDR, 32'h0000_0001);
		apb(0, CFG_BASE, 0);
		chk(rd, 40'(CFG_RESET));
		apb(0, 12'h020, 0);
		chk({e, rd}, {1'b1, 32'h0000_0000});
		// A misaligned word address is refused just like a hole in the map.
		apb(0, CFG_BASE + 12'h002, 0);
		chk({e, rd}, {1'b1, 32'h0000_0000});
		wr(GMASK_BASE, 32'h0000_0010);
		// Every class code on port 1 counter 0; no destination stands in for an error.
		for (c = 0; c < 8; c++) begin
			wr(CLEAR_ADDR, 32'h0000_0001);
			wr(CFG_BASE + 12'h010, {21'h0, c[2:0], 8'hFF});
			frame(1, 0, 0, 0, 64, 12'h000, 0);
			frame(1, 1, 0, 0, 64, 12'h010, 0);
			frame(1, 2, 1, 0, 64, 12'h030, 0);
			frame(1, 3, 0, 1, 64, 12'h000, 0);
			n = hit(c, 0, 0) + hit(c, 0, 1) + hit(c, 1, 1) + hit(c, 1, 0);
			rd40(PCNT_BASE + 12'h020);
			chk(v, 40'(n));
		end
		apb(0, FLAGS_BASE + 12'h004, 0);
		chk(rd, 40'h030);
		wr(FLAGS_BASE + 12'h004, 32'h0000_0010);
		apb(0, FLAGS_BASE + 12'h004, 0);
		chk(rd, 40'h020);
		// Byte mode, priority 5 masked off, port 2 counter 1 only.
		wr(GMASK_BASE + 12'h004, 32'h0000_0800);
		wr(CFG_BASE + 12'h024, 32'h0000_0BDF);
		frame(2, 5, 0, 0, 100, 12'h800, 0);
		frame(2, 4, 0, 0, 1500, 12'h800, 0);
		frame(1, 4, 0, 0, 77, 12'h800, 0);
		frame(2, 4, 0, 0, 3, 12'h400, 0);
		rd40(PCNT_BASE + 12'h048);
		chk(v, 40'd1500);
		rd40(PCNT_BASE + 12'h028);
		chk(v, 40'd2);
		// Full-scale port counter wraps to zero.
		wr(PCNT_BASE, 32'hFFFF_FFFF);
		wr(PCNT_BASE + 12'h004, 32'h0000_00FF);
		rd40(PCNT_BASE);
		chk(v, 40'hFF_FFFF_FFFF);
		frame(0, 0, 0, 0, 1, 12'h000, 0);
		rd40(PCNT_BASE);
		chk(v, 40'h0);
		// Queue 11: pass events count frames, drop events count bytes.
		wr(QMASK_BASE, 32'h0000_0001);
		wr(QMASK_BASE + 12'h004, 32'h0000_0002);
		wr(QMODE_ADDR, 32'h0000_0002);
		wr(QCNT_BASE + 12'h0B4, 32'h0000_0012);
		wr(QCNT_BASE + 12'h0B0, 32'h0000_0005);
		frame(1, 3, 0, 0, 64, 12'h000, 2'b11);
		frame(1, 3, 0, 0, 10, 12'h000, 2'b01);
		rd40(QCNT_BASE + 12'h0B0);
		chk(v, 40'h12_0000_0007);
		// The shadow is shared: a high read of another counter still returns the latched bits.
		apb(0, PCNT_BASE + 12'h004, 0);
		chk(rd, 40'h12);
		rd40(QCNT_BASE + 12'h0B8);
		chk(v, 40'd64);
		rd40(QCNT_BASE + 12'h0C0);
		chk(v, 40'h0);
		// Global clear empties flags and both counter kinds.
		frame(1, 0, 0, 0, 1, 12'h801, 0);
		apb(0, FLAGS_BASE + 12'h004, 0);
		chk(rd, 40'h821);
		wr(CLEAR_ADDR, 32'h0000_0001);
		apb(0, FLAGS_BASE + 12'h004, 0);
		chk(rd, 40'h0);
		rd40(QCNT_BASE + 12'h0B0);
		chk(v, 40'h0);
		rd40(PCNT_BASE + 12'h048);
		chk(v, 40'h0);
		close_out();
	end
endmodule // ingress_port_queue_stat_counters_tb_top
`default_nettype wire

/* File: verification/ipqsc_properties.sv */
// Checker for the frame link and the APB answers of the statistics counters.
`timescale 1ns/1ns
`default_nettype none
module ipqsc_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req_valid,
	input wire logic [ipqsc_pkg::EVT_W-1:0] req_events,
	input wire logic [ipqsc_pkg::BYTES_W-1:0] req_bytes,
	input wire logic valid,
	input wire logic [ipqsc_pkg::EVT_W-1:0] events,
	input wire logic [ipqsc_pkg::BYTES_W-1:0] bytes,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// All checks live in the one clock domain.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_valid_follows_req: assert property (req_valid |=> valid) else $error("frame strobe lost");
	chk_no_extra_valid: assert property (!req_valid |=> !valid) else $error("frame strobe invented");
	chk_event_carried: assert property (req_valid |=> events == $past(req_events)) else $error("event bits changed");
	chk_bytes_carried: assert property (req_valid |=> bytes == $past(req_bytes)) else $error("length changed");
	chk_fields_held: assert property (!req_valid |=> $stable(events) && $stable(bytes)) else $error("fields moved");
	chk_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no answer after setup");
	chk_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
	chk_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
	chk_refused_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000) else $error("refused data");

	// The main scenarios must really happen.
	cov_frame: cover property (req_valid ##1 valid);
	cov_read: cover property (pready && !pwrite && !pslverr);
	cov_refused: cover property (pready && pslverr);
endmodule // ipqsc_properties
`default_nettype wire
